// *** art_pkg.sv ***
// constants for the auto-reload timer capture and one-pulse block
package art_pkg;
  // counter width and limits
  localparam int unsigned CNT_W    = 12;
  localparam logic [11:0] CNT_MAX  = 12'hFFF;
  localparam logic [11:0] CNT_ZERO = 12'h000;
  // byte offsets of the registers
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_CH3   = 8'h08;
  localparam logic [7:0] OFS_CH2   = 8'h0C;
  localparam logic [7:0] OFS_CAPH  = 8'h10;
  localparam logic [7:0] OFS_CAPL  = 8'h14;
  localparam logic [7:0] OFS_CNT1  = 8'h18;
  localparam logic [7:0] OFS_CNT2  = 8'h1C;
  localparam logic [7:0] OFS_RLD1  = 8'h20;
  localparam logic [7:0] OFS_RLD2  = 8'h24;
  localparam logic [7:0] OFS_DUT2  = 8'h28;
  localparam logic [7:0] OFS_DUT3  = 8'h2C;
  localparam logic [7:0] OFS_BRK   = 8'h30;
  // control register fields
  localparam int unsigned B_CAPF   = 6;
  localparam int unsigned B_CAPIE  = 5;
  localparam int unsigned B_CKSEL  = 3;
  // second control register fields
  localparam int unsigned B_SRC    = 0;
  localparam int unsigned B_EN2    = 1;
  localparam int unsigned B_TRANSFER_TWO  = 2;
  localparam int unsigned B_FRC1   = 3;
  localparam int unsigned B_FRC2   = 4;
  localparam int unsigned B_OVERFLOW_FLAG_TWO   = 5;
  localparam int unsigned B_OVIE2  = 6;
  // channel control fields
  localparam int unsigned B_OPEN   = 3;
  localparam int unsigned B_ONE_PULSE_EDGE_SELECT = 2;
  localparam int unsigned B_POL    = 1;
  // break register field
  localparam int unsigned B_BRK    = 0;
  // counter clock select codes
  localparam logic [1:0] CK_OFF    = 2'h0;
  localparam logic [1:0] CK_LITE   = 2'h1;
  localparam logic [1:0] CK_CPU    = 2'h2;
  localparam logic [1:0] CK_FAST   = 2'h3;
  // reset values
  localparam logic [11:0] RST_CNT  = 12'h000;
  localparam logic [11:0] RST_RLD  = 12'h000;
  localparam logic [11:0] RST_DUT  = 12'h000;
endpackage

// *** art_timer.sv ***
// timer core: input capture, one-pulse counter two, forced overflow, apb slave
`timescale 1ns/1ps
`default_nettype none

// Function
// [R01] capture edge copies counter one into hold
// [R02] capture sets flag; irq when enabled
// [R03] reading either capture half clears flag
// [R04] further captures ignored while flag set
// [R05] source select picks lite capture pin
// [R06] clock select 01 uses lite tick
// [R07] software sequence for changing capture source
// [R08] one-pulse only counter two, enabled bit
// [R09] edge select chooses trigger edge
// [R10] trigger clears counter two, output high
// [R11] early triggers ignored, later ones restart
// [R12] untriggered: count to reload, restart high
// [R13] output two same with own duty
// [R14] enable and edge bits act immediately
// [R15] polarity updates at overflow with transfer
// [R16] trigger to clear within 2-3 cycles
// [R17] priority: break, trigger, force, restart, normal
// [R18] overflow event on every counter-two restart
// [R19] software keeps reload above duty values
// [R20] break resets counter two, duty, reload
// [R21] force loads FFF, overflow, then reload
// [R22] force bit cleared at own overflow
// [R23] edge select 0 falling, 1 rising
// [R24] pins synchronised before edge detection
module art_timer
  import art_pkg::*;
#(
  parameter int unsigned CW = 12
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // external pins
  input  wire logic        capture_pin,
  input  wire logic        lite_capture_pin,
  input  wire logic        lite_tick,
  // outputs
  output logic             output_two,
  output logic             output_three,
  output logic             capture_irq,
  output logic             overflow_two_irq
);
  import art_pkg::*;

  if (CW != CNT_W) begin : g_chk
    $error("art_timer supports only a 12-bit counter");
  end

  // synchronisers: first stage is read only by the second
  logic [2:0] sync1_ff, sync2_ff, last_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      last_ff  <= 3'h0;
    end else begin
      sync1_ff <= {lite_tick, lite_capture_pin, capture_pin}; // [R24]
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
    end
  end

  // edges from synchronised levels
  wire cap_rise  = sync2_ff[0] & ~last_ff[0];
  wire cap_fall  = ~sync2_ff[0] & last_ff[0];
  wire lcap_rise = sync2_ff[1] & ~last_ff[1];
  wire lcap_fall = ~sync2_ff[1] & last_ff[1];
  wire lite_edge = sync2_ff[2] & ~last_ff[2];

  // control state
  logic        capf_ff, capie_ff, src_ff, en2_ff, transfer_two_ff;
  logic        frc1_ff, frc2_ff, overflow_flag_two_ff, ovie2_ff, brk_ff;
  logic        open_ff, one_pulse_edge_select_ff, pol2_ff, pol3_ff;
  logic [1:0]  cksel_ff;
  logic [11:0] hold_ff, cnt1_ff, cnt2_ff, rld1_ff, rld2_ff;
  logic [11:0] dut2_ff, dut3_ff, act2_ff, act3_ff;
  logic        apol2_ff, apol3_ff, raw2_ff, raw3_ff, armed_ff;

  // apb decode; zero wait states
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire hit_ctrl  = paddr == OFS_CTRL;
  wire hit_ctrl2 = paddr == OFS_CTRL2;
  wire hit_ch3   = paddr == OFS_CH3;
  wire hit_ch2   = paddr == OFS_CH2;
  wire hit_caph  = paddr == OFS_CAPH;
  wire hit_capl  = paddr == OFS_CAPL;
  wire hit_cnt1  = paddr == OFS_CNT1;
  wire hit_cnt2  = paddr == OFS_CNT2;
  wire hit_rld1  = paddr == OFS_RLD1;
  wire hit_rld2  = paddr == OFS_RLD2;
  wire hit_dut2  = paddr == OFS_DUT2;
  wire hit_dut3  = paddr == OFS_DUT3;
  wire hit_brk   = paddr == OFS_BRK;
  wire mapped = hit_ctrl | hit_ctrl2 | hit_ch3 | hit_ch2 | hit_caph
              | hit_capl | hit_cnt1 | hit_cnt2 | hit_rld1 | hit_rld2
              | hit_dut2 | hit_dut3 | hit_brk;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // write strobes
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_ctrl2 = wr & hit_ctrl2;
  wire wr_frc1  = wr_ctrl2 & pwdata[B_FRC1];
  wire wr_frc2  = wr_ctrl2 & pwdata[B_FRC2];

  // counter tick from clock select
  wire tick = (cksel_ff == CK_LITE) ? lite_edge        // [R06]
            : (cksel_ff != CK_OFF);

  // capture path
  wire cap_edge = src_ff ? (lcap_rise | lcap_fall)     // [R05]
                         : (cap_rise | cap_fall);
  wire cap_take = cap_edge & ~capf_ff;                 // [R04]
  wire cap_clr  = rd & (hit_caph | hit_capl) & capf_ff; // [R03]
  wire nxt_capf = cap_take | (capf_ff & ~cap_clr);     // [R02]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capf_ff <= 1'b0;
      hold_ff <= RST_CNT;
    end else begin
      capf_ff <= nxt_capf;
      if (cap_take) begin
        hold_ff <= cnt1_ff; // [R01]
      end
    end
  end

  // counter one with forced overflow
  wire wrap1 = tick & (cnt1_ff == CNT_MAX);
  logic [11:0] nxt_cnt1;
  assign nxt_cnt1 = wr_frc1 ? CNT_MAX                  // [R21]
                  : wrap1 ? rld1_ff
                  : tick ? cnt1_ff + 12'h001
                  : cnt1_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt1_ff <= RST_CNT;
    end else begin
      cnt1_ff <= nxt_cnt1;
    end
  end

  // counter two: one-pulse only when the second counter runs
  wire op     = open_ff & en2_ff;                      // [R08] [R14]
  wire run2   = en2_ff & tick & ~brk_ff;
  wire trg_e  = one_pulse_edge_select_ff ? lcap_rise : lcap_fall;     // [R09] [R23]
  wire trig   = op & trg_e & armed_ff & ~brk_ff;       // [R11]
  wire at_max = cnt2_ff == CNT_MAX;
  wire at_rld = op & (cnt2_ff == rld2_ff);             // [R12]
  wire wrap2  = run2 & (at_max | at_rld);
  wire overflow_flag_two_evt = trig | (wrap2 & ~wr_frc2);           // [R18]
  wire load2  = overflow_flag_two_evt & transfer_two_ff;

  // counter two next value, resolved in priority order
  logic [11:0] nxt_cnt2;
  assign nxt_cnt2 = brk_ff ? RST_CNT                   // [R17] [R20]
                  : trig ? CNT_ZERO                    // [R10] [R16]
                  : wr_frc2 ? CNT_MAX                  // [R21]
                  : wrap2 ? (op ? CNT_ZERO : rld2_ff)  // [R12]
                  : run2 ? cnt2_ff + 12'h001
                  : cnt2_ff;

  // pulse state: high at restart, low at active duty match
  wire m2 = cnt2_ff == act2_ff;
  wire m3 = cnt2_ff == act3_ff;
  wire nxt_raw2 = brk_ff ? 1'b0
                : overflow_flag_two_evt ? 1'b1                      // [R13]
                : m2 ? 1'b0
                : raw2_ff;
  wire nxt_raw3 = brk_ff ? 1'b0
                : overflow_flag_two_evt ? 1'b1                      // [R10]
                : m3 ? 1'b0
                : raw3_ff;
  wire nxt_armed = ~overflow_flag_two_evt & (armed_ff | m3);        // [R11]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt2_ff  <= RST_CNT;
      raw2_ff  <= 1'b0;
      raw3_ff  <= 1'b0;
      armed_ff <= 1'b1;
    end else begin
      cnt2_ff  <= nxt_cnt2;
      raw2_ff  <= nxt_raw2;
      raw3_ff  <= nxt_raw3;
      armed_ff <= nxt_armed;
    end
  end

  // active duty and polarity, transferred at counter-two overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act2_ff  <= RST_DUT;
      act3_ff  <= RST_DUT;
      apol2_ff <= 1'b0;
      apol3_ff <= 1'b0;
    end else if (brk_ff) begin
      act2_ff  <= RST_DUT; // [R20]
      act3_ff  <= RST_DUT;
    end else if (load2) begin
      act2_ff  <= dut2_ff;
      act3_ff  <= dut3_ff;
      apol2_ff <= pol2_ff; // [R15]
      apol3_ff <= pol3_ff;
    end
  end

  // polarity that goes live at this edge; the inverter must switch together
  // with the restart, else the stale polarity leaks out for one cycle
  // at every counter-two overflow that transfers a new polarity
  wire nxt_apol2 = (~brk_ff & load2) ? pol2_ff : apol2_ff; // [R15]
  wire nxt_apol3 = (~brk_ff & load2) ? pol3_ff : apol3_ff; // [R15]

  // registered outputs; break forces low after the inverter
  wire nxt_out2 = ~brk_ff & (nxt_raw2 ^ nxt_apol2);
  wire nxt_out3 = ~brk_ff & (nxt_raw3 ^ nxt_apol3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_two   <= 1'b0;
      output_three <= 1'b0;
    end else begin
      output_two   <= nxt_out2;
      output_three <= nxt_out3;
    end
  end

  // interrupt requests are plain levels of flag and enable
  assign capture_irq      = capf_ff & capie_ff;        // [R02]
  assign overflow_two_irq = overflow_flag_two_ff & ovie2_ff;        // [R18]

  // force and overflow flags: a set beats a clear in the same cycle
  wire overflow_flag_two_clr  = rd & hit_ctrl2;
  wire nxt_overflow_flag_two  = overflow_flag_two_evt | (overflow_flag_two_ff & ~overflow_flag_two_clr);
  wire nxt_frc1  = wr_frc1 | (frc1_ff & ~wrap1);       // [R22]
  wire nxt_frc2  = wr_frc2 | (frc2_ff & ~overflow_flag_two_evt);    // [R22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_two_ff <= 1'b0;
      frc1_ff <= 1'b0;
      frc2_ff <= 1'b0;
    end else begin
      overflow_flag_two_ff <= nxt_overflow_flag_two;
      frc1_ff <= nxt_frc1;
      frc2_ff <= nxt_frc2;
    end
  end

  // software control bits; source select order is up to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capie_ff <= 1'b0;
      cksel_ff <= CK_OFF;
      src_ff   <= 1'b0;
      en2_ff   <= 1'b0;
      transfer_two_ff <= 1'b1;
      ovie2_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        capie_ff <= pwdata[B_CAPIE];
        cksel_ff <= pwdata[B_CKSEL +: 2];
      end
      if (wr_ctrl2) begin
        src_ff   <= pwdata[B_SRC]; // [R07]
        en2_ff   <= pwdata[B_EN2];
        transfer_two_ff <= pwdata[B_TRANSFER_TWO];
        ovie2_ff <= pwdata[B_OVIE2];
      end
    end
  end

  // channel control and break bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_ff   <= 1'b0;
      one_pulse_edge_select_ff <= 1'b0;
      pol3_ff   <= 1'b0;
      pol2_ff   <= 1'b0;
      brk_ff    <= 1'b0;
    end else begin
      if (wr & hit_ch3) begin
        open_ff   <= pwdata[B_OPEN];   // [R14]
        one_pulse_edge_select_ff <= pwdata[B_ONE_PULSE_EDGE_SELECT]; // [R14]
        pol3_ff   <= pwdata[B_POL];
      end
      if (wr & hit_ch2) begin
        pol2_ff <= pwdata[B_POL];
      end
      if (wr & hit_brk) begin
        brk_ff <= pwdata[B_BRK];
      end
    end
  end

  // reload and duty preloads; break returns the counter-two set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rld1_ff <= RST_RLD;
      rld2_ff <= RST_RLD;
      dut2_ff <= RST_DUT;
      dut3_ff <= RST_DUT;
    end else begin
      if (wr & hit_rld1) begin
        rld1_ff <= pwdata[11:0];
      end
      if (brk_ff) begin
        rld2_ff <= RST_RLD; // [R20]
        dut2_ff <= RST_DUT;
        dut3_ff <= RST_DUT;
      end else begin
        if (wr & hit_rld2) begin
          rld2_ff <= pwdata[11:0]; // [R19]
        end
        if (wr & hit_dut2) begin
          dut2_ff <= pwdata[11:0];
        end
        if (wr & hit_dut3) begin
          dut3_ff <= pwdata[11:0];
        end
      end
    end
  end

  // read words assembled from state
  wire [31:0] rd_ctrl = {25'h0, capf_ff, capie_ff, cksel_ff, 3'h0};
  wire [31:0] rd_ctrl2 = {25'h0, ovie2_ff, overflow_flag_two_ff, frc2_ff, frc1_ff,
                          transfer_two_ff, en2_ff, src_ff};
  wire [31:0] rd_ch3 = {28'h0, open_ff, one_pulse_edge_select_ff, pol3_ff, 1'b0};
  wire [31:0] rd_ch2 = {30'h0, pol2_ff, 1'b0};

  // read mux; unmapped reads return zero
  always_comb begin
    prdata = 32'h0;
    unique case (1'b1)
      hit_ctrl:  prdata = rd_ctrl;
      hit_ctrl2: prdata = rd_ctrl2;
      hit_ch3:   prdata = rd_ch3;
      hit_ch2:   prdata = rd_ch2;
      hit_caph:  prdata = {28'h0, hold_ff[11:8]};
      hit_capl:  prdata = {24'h0, hold_ff[7:0]};
      hit_cnt1:  prdata = {20'h0, cnt1_ff};
      hit_cnt2:  prdata = {20'h0, cnt2_ff};
      hit_rld1:  prdata = {20'h0, rld1_ff};
      hit_rld2:  prdata = {20'h0, rld2_ff};
      hit_dut2:  prdata = {20'h0, dut2_ff};
      hit_dut3:  prdata = {20'h0, dut3_ff};
      hit_brk:   prdata = {31'h0, brk_ff};
      default:   prdata = 32'h0;
    endcase
  end

endmodule // art_timer

`default_nettype wire

// *** art_timer_monitor.sv ***
// checker for the timer core, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module art_monitor
  import art_pkg::*;
(
  // bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // outputs
  input wire logic        output_two,
  input wire logic        output_three,
  input wire logic        capture_irq,
  input wire logic        overflow_two_irq
);
  // access-phase decodes
  wire logic acc    = psel && penable;
  wire logic rd_cap = acc && !pwrite && (paddr == OFS_CAPH || paddr == OFS_CAPL);
  wire logic wr_ctl = acc && pwrite && paddr == OFS_CTRL;
  wire logic wr_ct2 = acc && pwrite && paddr == OFS_CTRL2;
  wire logic wr_brk = acc && pwrite && paddr == OFS_BRK;
  wire logic rd_z   = acc && !pwrite && (paddr == OFS_CNT2 || paddr == OFS_RLD2
                      || paddr == OFS_DUT2 || paddr == OFS_DUT3);
  logic brk_ff;
  logic ie_ff;
  logic ovie_ff;

  // shadow enables, so irq gating is judged without bus reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_ff  <= 1'b0;
      ie_ff   <= 1'b0;
      ovie_ff <= 1'b0;
    end else begin
      if (wr_brk) brk_ff <= pwdata[B_BRK];
      if (wr_ctl) ie_ff <= pwdata[B_CAPIE];
      if (wr_ct2) ovie_ff <= pwdata[B_OVIE2];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence brk_on_s;
    wr_brk && pwdata[B_BRK];
  endsequence
  sequence dark_s;
    !output_two && !output_three;
  endsequence

  cap_clear_a: assert property (rd_cap && capture_irq |=> !capture_irq)
    else $error("capture flag kept");
  cap_keep_a: assert property (capture_irq && !rd_cap && !wr_ctl |=> capture_irq)
    else $error("capture flag lost");
  cap_gate_a: assert property (!ie_ff |-> !capture_irq)
    else $error("capture irq masked");
  ovf_gate_a: assert property (!ovie_ff |-> !overflow_two_irq)
    else $error("overflow irq masked");
  brk_dark_a: assert property (brk_on_s |-> ##2 dark_s)
    else $error("outputs live in break");
  brk_zero_a: assert property (brk_ff && rd_z |-> prdata[11:0] == 12'h000)
    else $error("break left state");
  hold_width_a: assert property (rd_cap && paddr == OFS_CAPH |-> prdata[31:4] == 28'h0)
    else $error("hold too wide");
  cnt_width_a: assert property (acc && paddr == OFS_CNT1 |-> prdata[31:12] == 20'h0)
    else $error("counter too wide");
endmodule // art_monitor

bind art_timer art_monitor art_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .output_two(output_two),
  .output_three(output_three), .capture_irq(capture_irq), .overflow_two_irq(overflow_two_irq)
);
`default_nettype wire

// *** art_src.sv ***
// pulse source model for the capture, trigger and tick pins
`timescale 1ns/1ps
`default_nettype none
module art_src (
  // clock
  input  wire logic pclk,
  // pins
  output var logic  capture_pin,
  output var logic  lite_capture_pin,
  output var logic  lite_tick
);
  initial begin
    capture_pin      = 1'b0;
    lite_capture_pin = 1'b0;
    lite_tick        = 1'b0;
  end
  // pin changes land just after an edge, like any external source
  task automatic flip_cap();
    @(posedge pclk);
    capture_pin <= ~capture_pin;
  endtask
  task automatic set_lite(input logic v);
    @(posedge pclk);
    lite_capture_pin <= v;
  endtask
  // w sets tick width: small is prompt, large is slow; 3 or more clears the sync stages
  task automatic ticks(input int k, input int w);
    repeat (k) begin
      @(posedge pclk);
      lite_tick <= 1'b1;
      repeat (w) @(posedge pclk);
      lite_tick <= 1'b0;
      repeat (w - 1) @(posedge pclk);
    end
  endtask
endmodule // art_src
`default_nettype wire

// *** tb_art_timer.sv ***
// self-checking bench for the timer capture and one-pulse paths
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_art_timer;
  import art_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, serr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, rdat;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, output_two, output_three, capture_irq, overflow_two_irq;
  wire logic        capture_pin, lite_capture_pin, lite_tick;
  int               err_total, total_checks, n, hi, lo;

  art_timer art_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .lite_capture_pin(lite_capture_pin), .lite_tick(lite_tick),
    .output_two(output_two), .output_three(output_three), .capture_irq(capture_irq),
    .overflow_two_irq(overflow_two_irq));
  art_src art_src_inst (.pclk(pclk), .capture_pin(capture_pin),
    .lite_capture_pin(lite_capture_pin), .lite_tick(lite_tick));

  // 125 MHz
  always #4 pclk = ~pclk;

  // one apb transfer; the request stands until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic sig(input int s);
    return (s == 0) ? output_two : (s == 1) ? output_three : capture_irq;
  endfunction
  // bounded wait for a level; k counts the edges taken
  task automatic wt(input int s, input logic v, output int k);
    k = 0;
    while (sig(s) !== v && k < 9000) begin
      @(posedge pclk);
      k++;
    end
  endtask
  // one whole period of an output
  task automatic meas(input int s);
    wt(s, 1'b0, n);
    wt(s, 1'b1, n);
    wt(s, 1'b0, hi);
    wt(s, 1'b1, lo);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic t_capture();
    apb(1'b0, 8'h34, 32'h0);
    `CHK({serr, rdat}, 33'h100000000)
    apb(1'b1, OFS_CTRL, 32'h28);
    art_src_inst.ticks(5, 3);
    art_src_inst.flip_cap();
    wt(2, 1'b1, n);
    `CHK(capture_irq, 1'b1)
    art_src_inst.ticks(1, 6);
    art_src_inst.flip_cap();
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_CAPL, 32'h0);
    `CHK(rdat, 32'h5)
    @(posedge pclk);
    `CHK(capture_irq, 1'b0)
    apb(1'b0, OFS_CAPH, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, OFS_CNT1, 32'h0);
    `CHK(rdat, 32'h6)
    // source change in the safe order: mask, select, clear, unmask
    apb(1'b1, OFS_CTRL, 32'h08);
    apb(1'b1, OFS_CTRL2, 32'h05);
    apb(1'b0, OFS_CAPL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h28);
    art_src_inst.flip_cap();
    repeat (8) @(posedge pclk);
    `CHK(capture_irq, 1'b0)
    art_src_inst.set_lite(1'b1);
    wt(2, 1'b1, n);
    apb(1'b0, OFS_CAPL, 32'h0);
    `CHK(rdat, 32'h6)
    $display("capture test done");
  endtask

  task automatic t_pulse();
    art_src_inst.set_lite(1'b0);
    // reload kept above both duties, as software must
    apb(1'b1, OFS_RLD2, 32'h1E);
    apb(1'b1, OFS_DUT3, 32'h0C);
    apb(1'b1, OFS_DUT2, 32'h06);
    apb(1'b1, OFS_CTRL, 32'h10);
    apb(1'b1, OFS_CTRL2, 32'h56);
    repeat (2) @(posedge pclk);
    `CHK(overflow_two_irq, 1'b1)
    apb(1'b0, OFS_CTRL2, 32'h0);
    `CHK(rdat, 32'h66)
    apb(1'b0, OFS_CNT2, 32'h0);
    `CHK(rdat >= 32'h1E && rdat < 32'h30, 1'b1)
    apb(1'b1, OFS_CH3, 32'h0C);
    apb(1'b1, OFS_CTRL2, 32'h56);
    meas(1);
    // the duty compare is registered, so the output stays high through the duty count
    `CHK(hi, 12 + 1)
    `CHK(hi + lo, 31)
    meas(0);
    `CHK(hi, 6 + 1)
    `CHK(overflow_two_irq, 1'b1)
    // late rising trigger restarts at once
    wt(1, 1'b0, n);
    art_src_inst.set_lite(1'b1);
    wt(1, 1'b1, n);
    `CHK(n < 8, 1'b1)
    art_src_inst.set_lite(1'b0);
    repeat (2) @(posedge pclk);
    art_src_inst.set_lite(1'b1);
    wt(1, 1'b0, n);
    // five edges since the restart, fall seen one edge after duty plus one
    `CHK(n + 5, 12 + 2)
    art_src_inst.set_lite(1'b0);
    wt(1, 1'b1, n);
    // falling edge ignored: next rise only at the reload restart, 31 edges on
    `CHK(n + 14, 31)
    apb(1'b1, OFS_CH3, 32'h08);
    art_src_inst.set_lite(1'b1);
    wt(1, 1'b0, n);
    art_src_inst.set_lite(1'b0);
    wt(1, 1'b1, n);
    `CHK(n < 8, 1'b1)
    // inverting polarity mid-pulse must wait for the next counter-two overflow
    apb(1'b1, OFS_CH3, 32'h0A);
    @(posedge pclk);
    `CHK(output_three, 1'b1)
    wt(1, 1'b0, n);
    wt(1, 1'b1, n);
    `CHK(n, 31)
    $display("one-pulse test done");
  endtask

  task automatic t_break();
    logic [7:0] za [4] = '{OFS_CNT2, OFS_RLD2, OFS_DUT2, OFS_DUT3};
    apb(1'b1, OFS_BRK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, za[i], 32'h0);
      `CHK(rdat, 32'h0)
    end
    `CHK({output_two, output_three}, 2'b00)
    apb(1'b1, OFS_BRK, 32'h0);
    $display("break test done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_capture();
    t_pulse();
    t_break();
    end_sim();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_sim();
  end
endmodule // tb_art_timer
`default_nettype wire
